/* verilog/vdc_dma.sv */
// Summary of operation
// - channel 2 direction bit: 0 write, 1 read
// - channel 3 direction bit: 0 write, 1 read
// - byte order field reorders every passing word
// - read mode line count, zero means one line
// - read mode byte count, zero means one byte
// - channel 2 write mode ignores geometry fields
// - channel 3 write drops lines beyond count
// - channel 3 write drops bytes beyond count
// - separate odd and even field start addresses
// - stride added at every new line
// - page table base in bits 31 to 12
// - bit 11 enables address translation
// - range boundary crossing raises interrupt
// - range is two to five plus limit bytes
// - guard address reached interrupts and stops transfer, but wraps to field start if range limit set and violation stop off
// - violation stop mode drains, clears transfer enable
// - negative stride starts at base plus stride
`timescale 1ns/10ps
`default_nettype none
module vdc_dma (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic IRQ,
   input wire logic [31:0] CH2_DIN,
   input wire logic CH2_DIN_VALID,
   output logic [31:0] CH2_DOUT,
   output logic CH2_DOUT_VALID,
   input wire logic CH2_BOF,
   output logic CH2_READ_MODE,
   output logic CH2_FETCH,
   output logic CH2_FETCH_EOL,
   input wire logic [31:0] S3_DATA,
   input wire logic S3_VALID,
   input wire logic S3_EOL,
   input wire logic S3_BOF,
   input wire logic S3_ODD,
   output logic CH3_REQ,
   output logic CH3_WRITE,
   output logic [31:0] CH3_ADDR,
   output logic [31:0] CH3_WDATA,
   output logic CH3_TRANSLATE,
   output logic [19:0] CH3_TABLE_BASE,
   input wire logic [31:0] CH3_RDATA_IN,
   input wire logic CH3_RDATA_VALID,
   output logic [31:0] CH3_SC_DATA,
   output logic CH3_SC_VALID
);

   typedef struct packed {
      logic [31:0] page2;
      logic [31:0] geo2;
      logic [31:0] odd3;
      logic [31:0] even3;
      logic [31:0] guard3;
      logic [31:0] stride3;
      logic [31:0] ch3_table_and_handling;
      logic [31:0] geo3;
      logic [1:0] ctrl;
      logic [3:0] status;
      logic [3:0] mask;
      logic irq;
      logic [31:0] rdata;
      vdc_pkg::vdc_state_e st3;
      logic [31:0] addr;
      logic [31:0] line_start;
      logic [31:0] field_first;
      logic [12:0] bpos3;
      logic [12:0] lcnt3;
      logic c2_act;
      logic [12:0] bpos2;
      logic [12:0] lcnt2;
      logic c2_fetch;
      logic c2_eol;
      logic [31:0] c2_dout;
      logic c2_dvalid;
      logic c3_req;
      logic c3_write;
      logic [31:0] c3_addr;
      logic [31:0] c3_wdata;
      logic [31:0] c3_sc_data;
      logic c3_sc_valid;
   } vdc_state_s;

   vdc_state_s r;
   vdc_state_s next_r;

   logic dir2;
   logic dir3;
   logic en2;
   logic en3;
   logic pv3;
   logic [3:0] ch3_irq_range;
   logic [11:0] bytes2;
   logic [11:0] lines2;
   logic [11:0] bytes3;
   logic [11:0] lines3;
   logic [31:0] first_addr;
   logic [31:0] rmask;
   logic [31:0] step_addr;
   logic [12:0] bpos3_inc;
   logic [12:0] bpos2_inc;
   logic [3:0] ev;
   logic word_go;
   logic in_window;
   logic line_end;

   // 11 is reserved and passes data unchanged
   function automatic logic [31:0] vdc_swap(input logic [31:0] d,
                                            input logic [1:0] mode);
      logic [31:0] q;
      q = d;
      if (mode == vdc_pkg::SWAP_HALF) begin
         q = {d[23:16], d[31:24], d[7:0], d[15:8]};
      end else if (mode == vdc_pkg::SWAP_FULL) begin
         q = {d[7:0], d[15:8], d[23:16], d[31:24]};
      end
      return q;
   endfunction : vdc_swap

   always_comb begin
      dir2 = r.page2[vdc_pkg::DIR_BIT];
      dir3 = r.ch3_table_and_handling[vdc_pkg::DIR_BIT];
      en2 = r.ctrl[vdc_pkg::CTL_EN2];
      en3 = r.ctrl[vdc_pkg::CTL_EN3];
      pv3 = r.ch3_table_and_handling[vdc_pkg::PV_BIT];
      ch3_irq_range = r.ch3_table_and_handling[vdc_pkg::LIM_LSB +: 4];
      bytes2 = r.geo2[vdc_pkg::BYTES_LSB +: 12];
      lines2 = r.geo2[vdc_pkg::LINES_LSB +: 12];
      bytes3 = r.geo3[vdc_pkg::BYTES_LSB +: 12];
      lines3 = r.geo3[vdc_pkg::LINES_LSB +: 12];
      // negative stride flips the field top-down
      first_addr = (S3_ODD ? r.odd3 : r.even3)
         + (r.stride3[31] ? r.stride3 : vdc_pkg::RST_REG);
      rmask = (32'h0000_0001 << (vdc_pkg::RANGE_EXP0 + {2'h0, ch3_irq_range}))
         - 32'h0000_0001;
      step_addr = r.addr + vdc_pkg::ADDR_STEP;
      bpos3_inc = 13'(r.bpos3 + vdc_pkg::WORD_BYTES);
      bpos2_inc = 13'(r.bpos2 + vdc_pkg::WORD_BYTES);
      ev = vdc_pkg::RST_EV;
      word_go = 1'b0;
      in_window = 1'b0;
      line_end = 1'b0;

      next_r = r;
      // rdata idles at zero, only the cycle after a read carries data
      next_r.rdata = vdc_pkg::RST_REG;
      next_r.c2_fetch = 1'b0;
      next_r.c2_eol = 1'b0;
      next_r.c3_req = 1'b0;
      next_r.c2_dvalid = CH2_DIN_VALID;
      next_r.c3_sc_valid = CH3_RDATA_VALID & dir3;

      // byte order on both data paths
      next_r.c2_dout = vdc_swap(CH2_DIN,
         r.page2[vdc_pkg::SWAP_LSB +: 2]);
      next_r.c3_sc_data = vdc_swap(CH3_RDATA_IN,
         r.ch3_table_and_handling[vdc_pkg::SWAP_LSB +: 2]);

      if (WR) begin
         unique case (ADDR)
            vdc_pkg::OFS_PAGE2: next_r.page2 = WDATA
               & vdc_pkg::WMASK_PAGE2;
            vdc_pkg::OFS_GEO2: next_r.geo2 = WDATA
               & vdc_pkg::WMASK_GEO;
            vdc_pkg::OFS_ODD3: next_r.odd3 = WDATA;
            vdc_pkg::OFS_EVEN3: next_r.even3 = WDATA;
            vdc_pkg::OFS_GUARD3: next_r.guard3 = WDATA
               & vdc_pkg::WMASK_GUARD;
            vdc_pkg::OFS_STRIDE3: next_r.stride3 = WDATA;
            vdc_pkg::OFS_CH3_TABLE_AND_HANDLING: next_r.ch3_table_and_handling = WDATA
               & vdc_pkg::WMASK_CH3_TABLE_AND_HANDLING;
            vdc_pkg::OFS_GEO3: next_r.geo3 = WDATA
               & vdc_pkg::WMASK_GEO;
            vdc_pkg::OFS_CTRL: next_r.ctrl = WDATA[1:0];
            vdc_pkg::OFS_STAT: next_r.status = r.status & ~WDATA[3:0];
            vdc_pkg::OFS_MASK: next_r.mask = WDATA[3:0];
            default: ;
         endcase
      end

      if (RD) begin
         unique case (ADDR)
            vdc_pkg::OFS_PAGE2: next_r.rdata = r.page2;
            vdc_pkg::OFS_GEO2: next_r.rdata = r.geo2;
            vdc_pkg::OFS_ODD3: next_r.rdata = r.odd3;
            vdc_pkg::OFS_EVEN3: next_r.rdata = r.even3;
            vdc_pkg::OFS_GUARD3: next_r.rdata = r.guard3;
            vdc_pkg::OFS_STRIDE3: next_r.rdata = r.stride3;
            vdc_pkg::OFS_CH3_TABLE_AND_HANDLING: next_r.rdata = r.ch3_table_and_handling;
            vdc_pkg::OFS_GEO3: next_r.rdata = r.geo3;
            vdc_pkg::OFS_CTRL: next_r.rdata = {30'h0, r.ctrl};
            vdc_pkg::OFS_STAT: next_r.rdata = {28'h000_0000, r.status};
            vdc_pkg::OFS_MASK: next_r.rdata = {28'h000_0000, r.mask};
            vdc_pkg::OFS_ADDR3: next_r.rdata = r.addr;
            default: next_r.rdata = vdc_pkg::RST_REG;
         endcase
      end

      // channel 2 fetch sequencer, only active in read direction
      // one fetch per cycle; the master has no way to stall it
      if (!en2 || !dir2) begin
         next_r.c2_act = 1'b0;
      end else if (CH2_BOF) begin
         next_r.c2_act = 1'b1;
         next_r.bpos2 = 13'h0000;
         next_r.lcnt2 = 13'h0000;
      end else if (r.c2_act) begin
         next_r.c2_fetch = 1'b1;
         next_r.bpos2 = bpos2_inc;
         if (bpos2_inc > {1'b0, bytes2}) begin
            next_r.bpos2 = 13'h0000;
            next_r.c2_eol = 1'b1;
            next_r.lcnt2 = 13'(r.lcnt2 + 13'h0001);
            if (r.lcnt2 >= {1'b0, lines2}) begin
               next_r.c2_act = 1'b0;
               ev[vdc_pkg::EV_C2_DONE] = 1'b1;
            end
         end
      end

      // channel 3 address generator and window trim
      unique case (r.st3)
         vdc_pkg::VDC_IDLE, vdc_pkg::VDC_HALT: begin
            if (!en3) begin
               next_r.st3 = vdc_pkg::VDC_IDLE;
            end else if (S3_BOF) begin
               next_r.st3 = vdc_pkg::VDC_RUN;
               next_r.addr = first_addr;
               next_r.line_start = first_addr;
               next_r.field_first = first_addr;
               next_r.bpos3 = 13'h0000;
               next_r.lcnt3 = 13'h0000;
            end
         end
         vdc_pkg::VDC_RUN: begin
            if (!en3) begin
               next_r.st3 = vdc_pkg::VDC_IDLE;
            end else if (S3_BOF) begin
               // resync to a new field even mid-transfer
               next_r.addr = first_addr;
               next_r.line_start = first_addr;
               next_r.field_first = first_addr;
               next_r.bpos3 = 13'h0000;
               next_r.lcnt3 = 13'h0000;
            end else begin
               word_go = dir3 ? 1'b1 : S3_VALID;
               // window counted in whole words, partial words round up
               in_window = (r.bpos3 <= {1'b0, bytes3})
                  && (r.lcnt3 <= {1'b0, lines3});
               if (word_go && in_window) begin
                  // guard low bits are reserved, so compare word addresses
                  if (r.addr[31:2] >= r.guard3[31:2]) begin
                     ev[vdc_pkg::EV_GUARD] = 1'b1;
                     if (pv3) begin
                        next_r.st3 = vdc_pkg::VDC_DRAIN;
                     end else if (ch3_irq_range != vdc_pkg::LIM_OFF) begin
                        // continuous mode wraps to the field start
                        next_r.addr = r.field_first;
                        next_r.line_start = r.field_first;
                     end else begin
                        next_r.st3 = vdc_pkg::VDC_HALT;
                     end
                  end else begin
                     next_r.c3_req = 1'b1;
                     next_r.c3_write = ~dir3;
                     next_r.c3_addr = r.addr;
                     next_r.c3_wdata = vdc_swap(S3_DATA,
                        r.ch3_table_and_handling[vdc_pkg::SWAP_LSB +: 2]);
                     next_r.addr = step_addr;
                     next_r.bpos3 = bpos3_inc;
                     // the word that ends a block raises it
                     if (ch3_irq_range != vdc_pkg::LIM_OFF
                         && (step_addr & rmask) == vdc_pkg::RST_REG) begin
                        ev[vdc_pkg::EV_RANGE] = 1'b1;
                     end
                     line_end = dir3 && (bpos3_inc > {1'b0, bytes3});
                  end
               end
               if (!dir3 && S3_VALID && S3_EOL) begin
                  line_end = 1'b1;
               end
               if (line_end && next_r.st3 == vdc_pkg::VDC_RUN) begin
                  next_r.line_start = r.line_start + r.stride3;
                  next_r.addr = r.line_start + r.stride3;
                  next_r.bpos3 = 13'h0000;
                  // hold the count just past the window
                  if (r.lcnt3 <= {1'b0, lines3}) begin
                     next_r.lcnt3 = 13'(r.lcnt3 + 13'h0001);
                  end
                  if (dir3 && r.lcnt3 >= {1'b0, lines3}) begin
                     ev[vdc_pkg::EV_C3_DONE] = 1'b1;
                     next_r.st3 = vdc_pkg::VDC_HALT;
                  end
               end
            end
         end
         vdc_pkg::VDC_DRAIN: begin
            // no words are held here, so draining ends at once
            next_r.ctrl[vdc_pkg::CTL_EN3] = 1'b0;
            next_r.st3 = vdc_pkg::VDC_IDLE;
         end
      endcase

      // a new event wins over a clearing write in the same cycle
      next_r.status = next_r.status | ev;
      next_r.irq = |(next_r.status & next_r.mask);
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         r <= '0;
         r.st3 <= vdc_pkg::VDC_IDLE;
         r.ctrl <= vdc_pkg::RST_CTRL;
      end else begin
         r <= next_r;
      end
   end

   assign RDATA = r.rdata;
   assign IRQ = r.irq;
   assign CH2_DOUT = r.c2_dout;
   assign CH2_DOUT_VALID = r.c2_dvalid;
   assign CH2_READ_MODE = r.page2[vdc_pkg::DIR_BIT];
   assign CH2_FETCH = r.c2_fetch;
   assign CH2_FETCH_EOL = r.c2_eol;
   assign CH3_REQ = r.c3_req;
   assign CH3_WRITE = r.c3_write;
   assign CH3_ADDR = r.c3_addr;
   assign CH3_WDATA = r.c3_wdata;
   assign CH3_TRANSLATE = r.ch3_table_and_handling[vdc_pkg::ME_BIT];
   assign CH3_TABLE_BASE = r.ch3_table_and_handling[31:vdc_pkg::TBL_LSB];
   assign CH3_SC_DATA = r.c3_sc_data;
   assign CH3_SC_VALID = r.c3_sc_valid;

endmodule : vdc_dma
`default_nettype wire

/* inc/vdc_pkg.sv */
package vdc_pkg;
   // register offsets
   localparam logic [7:0] OFS_PAGE2 = 8'h28;
   localparam logic [7:0] OFS_GEO2 = 8'h2C;
   localparam logic [7:0] OFS_ODD3 = 8'h30;
   localparam logic [7:0] OFS_EVEN3 = 8'h34;
   localparam logic [7:0] OFS_GUARD3 = 8'h38;
   localparam logic [7:0] OFS_STRIDE3 = 8'h3C;
   localparam logic [7:0] OFS_CH3_TABLE_AND_HANDLING = 8'h40;
   localparam logic [7:0] OFS_GEO3 = 8'h44;
   localparam logic [7:0] OFS_CTRL = 8'h48;
   localparam logic [7:0] OFS_STAT = 8'h4C;
   localparam logic [7:0] OFS_MASK = 8'h50;
   localparam logic [7:0] OFS_ADDR3 = 8'h54;
   // field positions
   localparam int SWAP_LSB = 0;
   localparam int DIR_BIT = 2;
   localparam int PV_BIT = 3;
   localparam int LIM_LSB = 4;
   localparam int ME_BIT = 11;
   localparam int TBL_LSB = 12;
   localparam int BYTES_LSB = 0;
   localparam int LINES_LSB = 16;
   localparam int CTL_EN2 = 0;
   localparam int CTL_EN3 = 1;
   localparam int EV_GUARD = 0;
   localparam int EV_RANGE = 1;
   localparam int EV_C2_DONE = 2;
   localparam int EV_C3_DONE = 3;
   // writable bits of each register
   localparam logic [31:0] WMASK_PAGE2 = 32'h0000_0007;
   localparam logic [31:0] WMASK_GEO = 32'h0FFF_0FFF;
   localparam logic [31:0] WMASK_GUARD = 32'hFFFF_FFFC;
   localparam logic [31:0] WMASK_CH3_TABLE_AND_HANDLING = 32'hFFFF_F8FF;
   localparam logic [31:0] RST_REG = 32'h0000_0000;
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [3:0] RST_EV = 4'h0;
   localparam logic [1:0] SWAP_HALF = 2'h1;
   localparam logic [1:0] SWAP_FULL = 2'h2;
   localparam logic [3:0] LIM_OFF = 4'h0;
   localparam logic [5:0] RANGE_EXP0 = 6'h05;
   localparam logic [12:0] WORD_BYTES = 13'h004;
   localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

   typedef enum logic [1:0] {
      VDC_IDLE = 2'h0,
      VDC_RUN = 2'h1,
      VDC_DRAIN = 2'h2,
      VDC_HALT = 2'h3
   } vdc_state_e;
endpackage : vdc_pkg

/* tb/vdc_dma_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module vdc_dma_monitor (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic IRQ,
   input wire logic CH2_DIN_VALID,
   input wire logic CH2_DOUT_VALID,
   input wire logic CH2_READ_MODE,
   input wire logic CH2_FETCH,
   input wire logic CH2_FETCH_EOL,
   input wire logic S3_VALID,
   input wire logic CH3_REQ,
   input wire logic CH3_WRITE,
   input wire logic CH3_TRANSLATE,
   input wire logic [19:0] CH3_TABLE_BASE,
   input wire logic CH3_RDATA_VALID,
   input wire logic CH3_SC_VALID
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   property p_idle; !$past(RD) |-> RDATA == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("rdata not idle");
   property p_unmap; RD && ADDR > 8'h54 |=> RDATA == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_glow; RD && ADDR == vdc_pkg::OFS_GUARD3 |=> RDATA[1:0] == 2'h0;
   endproperty
   a_glow: assert property (p_glow) else $error("guard low bits");
   property p_dir2; WR && ADDR == vdc_pkg::OFS_PAGE2 |->
      ##2 CH2_READ_MODE == $past(WDATA[2], 2); endproperty
   a_dir2: assert property (p_dir2) else $error("ch2 direction");
   property p_xl; WR && ADDR == vdc_pkg::OFS_CH3_TABLE_AND_HANDLING |->
      ##2 CH3_TRANSLATE == $past(WDATA[11], 2); endproperty
   a_xl: assert property (p_xl) else $error("translate enable");
   property p_tb; WR && ADDR == vdc_pkg::OFS_CH3_TABLE_AND_HANDLING |->
      ##2 CH3_TABLE_BASE == $past(WDATA[31:12], 2); endproperty
   a_tb: assert property (p_tb) else $error("table base");
   property p_dout; CH2_DOUT_VALID |-> $past(CH2_DIN_VALID); endproperty
   a_dout: assert property (p_dout) else $error("dout without din");
   property p_sc; CH3_SC_VALID |-> $past(CH3_RDATA_VALID); endproperty
   a_sc: assert property (p_sc) else $error("scaler data");
   property p_req; CH3_REQ && CH3_WRITE |-> $past(S3_VALID); endproperty
   a_req: assert property (p_req) else $error("request without word");
   property p_eol; CH2_FETCH_EOL |-> CH2_FETCH; endproperty
   a_eol: assert property (p_eol) else $error("lone fetch end");
   property p_fm; CH2_FETCH |-> CH2_READ_MODE; endproperty
   a_fm: assert property (p_fm) else $error("fetch in write mode");
   c_wreq: cover property (CH3_REQ && CH3_WRITE);
   c_eol: cover property (CH2_FETCH_EOL);
   c_sc: cover property (CH3_SC_VALID);
   c_irq: cover property ($rose(IRQ));
endmodule : vdc_dma_monitor
bind vdc_dma vdc_dma_monitor vdc_dma_monitor_inst (.CLK(CLK), .RST_N(RST_N),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
   .CH2_DIN_VALID(CH2_DIN_VALID), .CH2_DOUT_VALID(CH2_DOUT_VALID),
   .CH2_READ_MODE(CH2_READ_MODE), .CH2_FETCH(CH2_FETCH),
   .CH2_FETCH_EOL(CH2_FETCH_EOL), .S3_VALID(S3_VALID), .CH3_REQ(CH3_REQ),
   .CH3_WRITE(CH3_WRITE), .CH3_TRANSLATE(CH3_TRANSLATE),
   .CH3_TABLE_BASE(CH3_TABLE_BASE), .CH3_RDATA_VALID(CH3_RDATA_VALID),
   .CH3_SC_VALID(CH3_SC_VALID));
`default_nettype wire

/* tb/vdc_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module vdc_mem_model (
   input wire logic clk,
   input wire logic [3:0] lat,
   input wire logic req,
   input wire logic write,
   input wire logic [31:0] addr,
   output logic [31:0] rdata,
   output logic rvalid
);
   logic [31:0] q[$];
   int cnt = 0;
   initial begin
      rdata = 32'h0;
      rvalid = 1'b0;
   end
   // idle data toggles so stale words never look valid
   always @(posedge clk) begin
      rvalid <= 1'b0;
      rdata <= ~rdata;
      if (req && !write) q.push_back(addr);
      if (q.size() > 0 && cnt >= lat) begin
         rdata <= q.pop_front() ^ 32'h5A5A_0000;
         rvalid <= 1'b1;
         cnt <= 0;
      end else cnt <= cnt + 1;
   end
endmodule : vdc_mem_model
`default_nettype wire

/* tb/vdc_dma_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("Error %s exp %h got %h", n, e, g); end end
module vdc_dma_tb;
   logic CLK, RST_N, WR, RD, IRQ, CH2_DIN_VALID, CH2_DOUT_VALID, CH2_BOF;
   logic CH2_READ_MODE, CH2_FETCH, CH2_FETCH_EOL, S3_VALID, S3_EOL, S3_BOF;
   logic S3_ODD, CH3_REQ, CH3_WRITE, CH3_TRANSLATE, CH3_RDATA_VALID;
   logic CH3_SC_VALID;
   logic [7:0] ADDR;
   logic [31:0] WDATA, RDATA, CH2_DIN, CH2_DOUT, S3_DATA, CH3_ADDR, sc;
   logic [31:0] CH3_WDATA, CH3_RDATA_IN, CH3_SC_DATA;
   logic [19:0] CH3_TABLE_BASE;
   logic [31:0] q[$];
   int fails, compares, cyc, nf, ne, i;
   logic [7:0] ofs[8] = '{8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40,
      8'h44};
   logic [31:0] msk[8] = '{vdc_pkg::WMASK_PAGE2, vdc_pkg::WMASK_GEO,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, vdc_pkg::WMASK_GUARD, 32'hFFFF_FFFF,
      vdc_pkg::WMASK_CH3_TABLE_AND_HANDLING, vdc_pkg::WMASK_GEO};
   logic [31:0] swp[4] = '{32'h4433_2211, 32'h3344_1122, 32'h1122_3344,
      32'h4433_2211};
   vdc_dma vdc_dma_inst (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
      .CH2_DIN(CH2_DIN), .CH2_DIN_VALID(CH2_DIN_VALID), .CH2_DOUT(CH2_DOUT),
      .CH2_DOUT_VALID(CH2_DOUT_VALID), .CH2_BOF(CH2_BOF),
      .CH2_READ_MODE(CH2_READ_MODE), .CH2_FETCH(CH2_FETCH),
      .CH2_FETCH_EOL(CH2_FETCH_EOL), .S3_DATA(S3_DATA), .S3_VALID(S3_VALID),
      .S3_EOL(S3_EOL), .S3_BOF(S3_BOF), .S3_ODD(S3_ODD), .CH3_REQ(CH3_REQ),
      .CH3_WRITE(CH3_WRITE), .CH3_ADDR(CH3_ADDR), .CH3_WDATA(CH3_WDATA),
      .CH3_TRANSLATE(CH3_TRANSLATE), .CH3_TABLE_BASE(CH3_TABLE_BASE),
      .CH3_RDATA_IN(CH3_RDATA_IN), .CH3_RDATA_VALID(CH3_RDATA_VALID),
      .CH3_SC_DATA(CH3_SC_DATA), .CH3_SC_VALID(CH3_SC_VALID));
   vdc_mem_model vdc_mem_model_inst (.clk(CLK), .lat(4'h3), .req(CH3_REQ),
      .write(CH3_WRITE), .addr(CH3_ADDR), .rdata(CH3_RDATA_IN),
      .rvalid(CH3_RDATA_VALID));
   always #5 CLK = ~CLK;
   always @(posedge CLK) begin
      cyc++;
      if (CH2_FETCH === 1'b1) nf++;
      if (CH2_FETCH_EOL === 1'b1) ne++;
      if (CH3_REQ === 1'b1) q.push_back(CH3_ADDR);
      if (CH3_SC_VALID === 1'b1) sc = CH3_SC_DATA;
      if (cyc == 3000) begin
         fails++;
         finish_test();
      end
   end
   task finish_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR <= a; WDATA <= d; WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge CLK);
      ADDR <= a; RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 `CHK("rdata", e, RDATA)
   endtask : rd
   task tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : tick
   task s3(input logic [31:0] d, input logic e);
      @(posedge CLK);
      S3_DATA <= d; S3_VALID <= 1'b1; S3_EOL <= e;
      @(posedge CLK);
      S3_VALID <= 1'b0; S3_EOL <= 1'b0;
   endtask : s3
   task bof(input logic two, input logic odd);
      @(posedge CLK);
      if (two) CH2_BOF <= 1'b1; else S3_BOF <= 1'b1;
      S3_ODD <= odd;
      @(posedge CLK);
      CH2_BOF <= 1'b0; S3_BOF <= 1'b0;
   endtask : bof
   task t_regs();
      for (i = 0; i < 8; i++) begin
         rd(ofs[i], 32'h0);
         wr(ofs[i], 32'hFFFF_FFFF);
         rd(ofs[i], msk[i]);
      end
      `CHK("xlate", 1'b1, CH3_TRANSLATE)
      `CHK("tbase", 20'hFFFFF, CH3_TABLE_BASE)
      rd(8'h58, 32'h0);
   endtask : t_regs
   task t_swap();
      for (i = 0; i < 4; i++) begin
         wr(vdc_pkg::OFS_PAGE2, i);
         @(posedge CLK);
         CH2_DIN <= 32'h4433_2211; CH2_DIN_VALID <= 1'b1;
         @(posedge CLK);
         CH2_DIN_VALID <= 1'b0;
         #1 `CHK("dout", swp[i], CH2_DOUT)
         `CHK("dval", 1'b1, CH2_DOUT_VALID)
      end
   endtask : t_swap
   task t_ch2();
      wr(vdc_pkg::OFS_PAGE2, 32'h4);
      wr(vdc_pkg::OFS_GEO2, 32'h0001_0007);
      wr(vdc_pkg::OFS_CTRL, 32'h1);
      nf = 0; ne = 0;
      bof(1'b1, 1'b0);
      tick(20);
      `CHK("mode", 1'b1, CH2_READ_MODE)
      `CHK("fetch", 4, nf)
      `CHK("eol", 2, ne)
      rd(vdc_pkg::OFS_STAT, 32'h4);
      wr(vdc_pkg::OFS_PAGE2, 32'h0);
      nf = 0;
      bof(1'b1, 1'b0);
      tick(20);
      `CHK("wfetch", 0, nf)
      wr(vdc_pkg::OFS_STAT, 32'hF);
   endtask : t_ch2
   task t_ch3w();
      wr(vdc_pkg::OFS_ODD3, 32'h1038);
      wr(vdc_pkg::OFS_EVEN3, 32'h2000);
      wr(vdc_pkg::OFS_STRIDE3, 32'h100);
      wr(vdc_pkg::OFS_GUARD3, 32'hFFFF_0000);
      wr(vdc_pkg::OFS_GEO3, 32'h0001_0007);
      wr(vdc_pkg::OFS_CH3_TABLE_AND_HANDLING, 32'h10);
      wr(vdc_pkg::OFS_MASK, 32'h2);
      wr(vdc_pkg::OFS_CTRL, 32'h2);
      q.delete();
      bof(1'b0, 1'b1);
      s3(32'h1, 1'b0); s3(32'h2, 1'b1);
      s3(32'h3, 1'b0); s3(32'h4, 1'b0); s3(32'h5, 1'b1);
      s3(32'h6, 1'b1);
      tick(3);
      `CHK("nreq", 4, q.size())
      `CHK("a1", 32'h103C, q[1])
      `CHK("a2", 32'h1138, q[2])
      `CHK("a3", 32'h113C, q[3])
      `CHK("wdata", 32'h4, CH3_WDATA)
      `CHK("write", 1'b1, CH3_WRITE)
      `CHK("irq", 1'b1, IRQ)
      rd(vdc_pkg::OFS_STAT, 32'h2);
      wr(vdc_pkg::OFS_STAT, 32'h2);
      tick(2);
      `CHK("irqclr", 1'b0, IRQ)
      wr(vdc_pkg::OFS_STRIDE3, 32'hFFFF_FF00);
      q.delete();
      bof(1'b0, 1'b0);
      s3(32'h7, 1'b1);
      tick(3);
      `CHK("neg", 32'h1F00, q[0])
   endtask : t_ch3w
   task t_guard();
      wr(vdc_pkg::OFS_STRIDE3, 32'h0);
      wr(vdc_pkg::OFS_GUARD3, 32'h2008);
      // window wide enough that the third word reaches the guard
      wr(vdc_pkg::OFS_GEO3, 32'h0001_00FF);
      wr(vdc_pkg::OFS_CH3_TABLE_AND_HANDLING, 32'h8);
      wr(vdc_pkg::OFS_MASK, 32'h1);
      wr(vdc_pkg::OFS_STAT, 32'hF);
      q.delete();
      bof(1'b0, 1'b0);
      for (i = 0; i < 4; i++) s3(i, 1'b0);
      tick(3);
      `CHK("greq", 2, q.size())
      `CHK("girq", 1'b1, IRQ)
      rd(vdc_pkg::OFS_CTRL, 32'h0);
      wr(vdc_pkg::OFS_MASK, 32'h0);
      tick(2);
      `CHK("masked", 1'b0, IRQ)
      wr(vdc_pkg::OFS_STAT, 32'hF);
   endtask : t_guard
   task t_ch3r();
      wr(vdc_pkg::OFS_ODD3, 32'h1000);
      wr(vdc_pkg::OFS_GEO3, 32'h3);
      wr(vdc_pkg::OFS_CH3_TABLE_AND_HANDLING, 32'h6);
      wr(vdc_pkg::OFS_CTRL, 32'h2);
      q.delete();
      bof(1'b0, 1'b1);
      tick(15);
      `CHK("rreq", 1, q.size())
      `CHK("raddr", 32'h1000, q[0])
      `CHK("rwrite", 1'b0, CH3_WRITE)
      `CHK("sc", 32'h0010_5A5A, sc)
      rd(vdc_pkg::OFS_STAT, 32'h8);
   endtask : t_ch3r
   initial begin
      CLK = 0; RST_N = 0; WR = 0; RD = 0; ADDR = 0; WDATA = 0;
      CH2_DIN = 0; CH2_DIN_VALID = 0; CH2_BOF = 0; S3_DATA = 0;
      S3_VALID = 0; S3_EOL = 0; S3_BOF = 0; S3_ODD = 0;
      repeat (2) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      t_regs();
      t_swap();
      t_ch2();
      t_ch3w();
      t_guard();
      t_ch3r();
      finish_test();
   end
endmodule : vdc_dma_tb
`default_nettype wire
